// ===== logic/pmev_bank.sv
// Behaviour
// [R1] button flag sets after 16 ms low
// [R2] flags hardware-set, software writes one clear
// [R3] held over 4 s: override replaces press
// [R4] firmware release write sets global flag
// [R5] any bus request sets busmaster flag
// [R6] timer bit 23 toggle sets timer flag
// [R7] timer enable routes timer flag to CONTROL_METHOD_INTERRUPT
// [R8] alarm enable routes alarm flag to resume
// [R9] button enable routes button flag to interrupts
// [R10] button always produces resume event
// [R11] global enable routes global flag to CONTROL_METHOD_INTERRUPT
// [R12] suspend trigger reads back zero
// [R13] trigger write starts selected suspend sequence
// [R14] kind field bits 12:10, 000 soft-off
// [R15] 100 pos, 101 working, 110/111 reserved
// [R16] override forces soft-off entry
// [R17] interrupt outputs are levels until cleared
`timescale 1ns/1ps
`include "pmev_cfg.svh"
module pmev_bank import pmev_pkg::*; #(
	parameter int unsigned DEBOUNCE_CYC = `PMEV_DEBOUNCE_CYC,
	parameter int unsigned OVERRIDE_CYC = `PMEV_OVERRIDE_CYC,
	parameter int unsigned NUM_REQ = 4
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [7:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [15:0] io_wdata_in,
	output logic [15:0] io_rdata_out,
	input wire logic button_in_n,
	input wire logic [NUM_REQ-1:0] pci_request_inputs_in,
	input wire logic pcpci_hold_request_n_in,
	input wire logic timer_msb_in,
	input wire logic alarm_in,
	output logic control_method_interrupt_out,
	output logic system_mgmt_interrupt_n_out,
	output logic resume_event_out,
	output logic suspend_start_out,
	output logic [2:0] suspend_kind_out,
	output logic suspend_kind_valid_out
);
	initial begin
		if (NUM_REQ < 1 || NUM_REQ > 16)
			$error("pmev_bank: NUM_REQ out of range");
	end

	pmev_btn_if btn();
	logic [15:0] status;
	logic [15:0] enable;
	logic [15:0] control;
	// pci requests, hold, timer msb, alarm: NUM_REQ + 3 sampled pins
	logic [NUM_REQ+2:0] req_s1;
	logic [NUM_REQ+2:0] req_s2;
	logic [15:0] next_status;
	logic [15:0] set_bits;
	logic [15:0] clr_bits;
	logic wr_status;
	logic wr_enable;
	logic wr_control;
	logic rd_any;

	pmev_button #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC),
		.OVERRIDE_CYC(OVERRIDE_CYC)
	) i_pmev_button (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.button_in_n(button_in_n),
		.btn(btn.watcher)
	);

	// decode used by the write strobes; the read path decodes with its own case
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wr_status = io_wr_in && hit(io_addr_in, `PMEV_OFS_STATUS);
	assign wr_enable = io_wr_in && hit(io_addr_in, `PMEV_OFS_ENABLE);
	assign wr_control = io_wr_in && hit(io_addr_in, `PMEV_OFS_CONTROL);
	assign rd_any = io_rd_in;

	// --------------------------------------------------------------
	// event inputs: all from pins, so two flops each
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			req_s1 <= '0;
			req_s2 <= '0;
		end else begin
			req_s1 <= {alarm_in, timer_msb_in, ~pcpci_hold_request_n_in, pci_request_inputs_in};
			req_s2 <= req_s1;
		end
	end

	logic timer_last;
	logic alarm_last;
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			timer_last <= 1'b0;
			alarm_last <= 1'b0;
		end else begin
			timer_last <= req_s2[NUM_REQ+1];
			alarm_last <= req_s2[NUM_REQ+2];
		end
	end

	// flag sources; set is applied after clear so a coincident event wins
	always_comb begin
		set_bits = 16'h0000;
		set_bits[`PMEV_BIT_TIMER] = req_s2[NUM_REQ+1] ^ timer_last; // R6
		set_bits[`PMEV_BIT_BUSMASTER] = |req_s2[NUM_REQ:0]; // R5
		set_bits[`PMEV_BIT_GLOBAL] = wr_control && io_wdata_in[`PMEV_BIT_RELEASE]; // R4
		set_bits[`PMEV_BIT_BUTTON] = btn.press_pulse; // R1
		set_bits[`PMEV_BIT_OVERRIDE] = btn.override_pulse; // R3
		set_bits[`PMEV_BIT_ALARM] = req_s2[NUM_REQ+2] & ~alarm_last;
		clr_bits = wr_status ? io_wdata_in : 16'h0000; // R2
		if (btn.override_pulse)
			clr_bits[`PMEV_BIT_BUTTON] = 1'b1; // R3
		next_status = ((status & ~clr_bits) | set_bits) & `PMEV_STATUS_MASK;
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			status <= `PMEV_STATUS_RESET;
		else
			status <= next_status; // R2
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			enable <= `PMEV_ENABLE_RESET;
		else if (wr_enable)
			enable <= io_wdata_in & `PMEV_ENABLE_MASK;
	end

	// trigger bit is never stored, only the kind field
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in)
			control <= `PMEV_CONTROL_RESET;
		else if (wr_control)
			control <= io_wdata_in & `PMEV_CONTROL_MASK; // R12
	end

	// read data registered; trigger reads as zero
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			io_rdata_out <= 16'h0000;
		end else if (rd_any) begin
			case (io_addr_in)
				`PMEV_OFS_STATUS: io_rdata_out <= status;
				`PMEV_OFS_ENABLE: io_rdata_out <= enable;
				`PMEV_OFS_CONTROL: io_rdata_out <= control; // R12
				default: io_rdata_out <= 16'h0000;
			endcase
		end
	end

	// --------------------------------------------------------------
	// interrupt routing held as levels; resume is a one-cycle pulse
	// --------------------------------------------------------------
	logic sci_next;
	logic smi_next;
	assign sci_next = (status[`PMEV_BIT_TIMER] & enable[`PMEV_BIT_TIMER]) // R7
		| (status[`PMEV_BIT_GLOBAL] & enable[`PMEV_BIT_GLOBAL]) // R11
		| (status[`PMEV_BIT_BUTTON] & enable[`PMEV_BIT_BUTTON]); // R9
	assign smi_next = status[`PMEV_BIT_BUTTON] & enable[`PMEV_BIT_BUTTON]; // R9

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			control_method_interrupt_out <= 1'b0;
			system_mgmt_interrupt_n_out <= 1'b1;
			resume_event_out <= 1'b0;
		end else begin
			control_method_interrupt_out <= sci_next; // R17
			system_mgmt_interrupt_n_out <= ~smi_next; // R17
			resume_event_out <= btn.press_pulse // R10
				| (set_bits[`PMEV_BIT_ALARM] & enable[`PMEV_BIT_ALARM]); // R8
		end
	end

	// suspend start: trigger write or override forcing soft-off
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			suspend_start_out <= 1'b0;
			suspend_kind_out <= PMEV_KIND_SOFT_OFF;
			suspend_kind_valid_out <= 1'b1;
		end else begin
			suspend_start_out <= btn.override_pulse // R16
				| (wr_control & io_wdata_in[`PMEV_BIT_TRIGGER]); // R13
			if (btn.override_pulse) begin
				suspend_kind_out <= PMEV_KIND_SOFT_OFF; // R16
				suspend_kind_valid_out <= 1'b1;
			end else if (wr_control && io_wdata_in[`PMEV_BIT_TRIGGER]) begin
				suspend_kind_out <= io_wdata_in[`PMEV_KIND_MSB:`PMEV_KIND_LSB]; // R14
				// reserved kinds flagged so the sequencer can ignore them
				suspend_kind_valid_out <= (io_wdata_in[`PMEV_KIND_MSB:`PMEV_KIND_LSB]
					!= PMEV_KIND_RSVD6) && (io_wdata_in[`PMEV_KIND_MSB:`PMEV_KIND_LSB]
					!= PMEV_KIND_RSVD7); // R15
			end
		end
	end

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	a_w1c_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(wr_status && io_wdata_in[`PMEV_BIT_GLOBAL] && !set_bits[`PMEV_BIT_GLOBAL])
		|=> !status[`PMEV_BIT_GLOBAL]) // R2
		else $error("global flag not cleared by write one");
	a_zero_write_keeps: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(wr_status && !io_wdata_in[`PMEV_BIT_BUSMASTER] && status[`PMEV_BIT_BUSMASTER])
		|=> status[`PMEV_BIT_BUSMASTER]) // R2
		else $error("busmaster flag lost on zero write");
	a_override_swap: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		btn.override_pulse |=> status[`PMEV_BIT_OVERRIDE] && !status[`PMEV_BIT_BUTTON]) // R3
		else $error("override did not replace press");
	a_override_low: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		btn.override_pulse |-> $past(btn.pressed)) // R3
		else $error("override without low button");
	a_release_global: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(wr_control && io_wdata_in[`PMEV_BIT_RELEASE]) |=> status[`PMEV_BIT_GLOBAL]) // R4
		else $error("release write missed");
	a_busreq_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(|req_s2[NUM_REQ:0]) |=> status[`PMEV_BIT_BUSMASTER]) // R5
		else $error("bus request missed");
	a_timer_toggle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(req_s2[NUM_REQ+1] != timer_last) |=> status[`PMEV_BIT_TIMER]) // R6
		else $error("timer toggle missed");
	a_sci_level: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(status[`PMEV_BIT_TIMER] && enable[`PMEV_BIT_TIMER]) |=> control_method_interrupt_out) // R7
		else $error("timer sci missing");
	a_sci_quiet: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(enable == 16'h0000) |=> !control_method_interrupt_out) // R9
		else $error("sci with all disabled");
	a_trigger_reads_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		!io_rdata_out[`PMEV_BIT_TRIGGER]) // R12
		else $error("trigger read back as one");
	a_suspend_start: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		(wr_control && io_wdata_in[`PMEV_BIT_TRIGGER]) |=> suspend_start_out) // R13
		else $error("suspend not started");
	a_resume_button: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		btn.press_pulse |=> resume_event_out) // R10
		else $error("button resume missing");

	c_press: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) btn.press_pulse);
	c_override: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) btn.override_pulse);
	c_suspend: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in) suspend_start_out);
	c_sci: cover property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		control_method_interrupt_out);
endmodule // pmev_bank

// ===== logic/pmev_btn_if.sv
// carrier between the button watcher and the register bank
`timescale 1ns/1ps
interface pmev_btn_if;
	logic press_pulse;
	logic override_pulse;
	logic pressed;
	modport watcher (output press_pulse, output override_pulse, output pressed);
	modport bank (input press_pulse, input override_pulse, input pressed);
endinterface

// ===== logic/pmev_button.sv
// power button synchroniser, debounce and long-press detector
`timescale 1ns/1ps
`include "pmev_cfg.svh"
module pmev_button import pmev_pkg::*; #(
	parameter int unsigned DEBOUNCE_CYC = `PMEV_DEBOUNCE_CYC,
	parameter int unsigned OVERRIDE_CYC = `PMEV_OVERRIDE_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic button_in_n,
	pmev_btn_if.watcher btn
);
	initial begin
		if (DEBOUNCE_CYC < 2 || OVERRIDE_CYC <= DEBOUNCE_CYC)
			$error("pmev_button: bad count parameters");
	end

	logic sync_a;
	logic sync_b;
	logic [31:0] count;
	pmev_btn_e state;

	// two flops, the button is asynchronous
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= button_in_n;
			sync_b <= sync_a;
		end
	end

	// --------------------------------------------------------------
	// debounce then long-press: count restarts on any release
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			state <= PMEV_BTN_IDLE;
			count <= 32'h0000_0000;
			btn.press_pulse <= 1'b0;
			btn.override_pulse <= 1'b0;
		end else begin
			btn.press_pulse <= 1'b0;
			btn.override_pulse <= 1'b0;
			if (sync_b) begin
				state <= PMEV_BTN_IDLE;
				count <= 32'h0000_0000;
			end else begin
				count <= count + 32'h0000_0001;
				case (state)
					PMEV_BTN_IDLE: begin
						state <= PMEV_BTN_DEBOUNCE;
					end
					PMEV_BTN_DEBOUNCE: begin
						if (count >= DEBOUNCE_CYC - 1) begin
							state <= PMEV_BTN_HELD;
							btn.press_pulse <= 1'b1; // R1
						end
					end
					PMEV_BTN_HELD: begin
						if (count >= OVERRIDE_CYC) begin
							state <= PMEV_BTN_OVERRIDDEN;
							btn.override_pulse <= 1'b1; // R3
						end
					end
					default: begin
						count <= count;
					end
				endcase
			end
		end
	end

	assign btn.pressed = ~sync_b;

	a_press_needs_low: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
		btn.press_pulse |-> $past(!sync_b)) // R1
		else $error("press pulse without low button");
endmodule // pmev_button

// ===== logic/pmev_cfg.svh
// offsets, field positions, reset values and timing counts of the pm event block
`ifndef PMEV_CFG_SVH
`define PMEV_CFG_SVH

`define PMEV_OFS_STATUS 8'h00
`define PMEV_OFS_ENABLE 8'h02
`define PMEV_OFS_CONTROL 8'h04

`define PMEV_BIT_TIMER 0
`define PMEV_BIT_BUSMASTER 4
`define PMEV_BIT_GLOBAL 5
`define PMEV_BIT_BUTTON 8
`define PMEV_BIT_ALARM 10
`define PMEV_BIT_OVERRIDE 11
`define PMEV_BIT_RELEASE 2
`define PMEV_BIT_TRIGGER 13
`define PMEV_KIND_LSB 10
`define PMEV_KIND_MSB 12

`define PMEV_ENABLE_RESET 16'h0000
`define PMEV_CONTROL_RESET 16'h0000
`define PMEV_ENABLE_MASK 16'h0521
`define PMEV_CONTROL_MASK 16'h1C00
`define PMEV_STATUS_RESET 16'h0000
`define PMEV_STATUS_MASK 16'h0D31

`define PMEV_CLK_MHZ 125
`define PMEV_DEBOUNCE_MS 16
`define PMEV_OVERRIDE_MS 4000
`define PMEV_DEBOUNCE_CYC (`PMEV_DEBOUNCE_MS * 1000 * `PMEV_CLK_MHZ)
`define PMEV_OVERRIDE_CYC (`PMEV_OVERRIDE_MS * 1000 * `PMEV_CLK_MHZ)

`endif

// ===== logic/pmev_pkg.sv
// types shared by the pm event block
package pmev_pkg;
	typedef enum logic [2:0] {
		PMEV_KIND_SOFT_OFF = 3'b000,
		PMEV_KIND_RAM = 3'b001,
		PMEV_KIND_CTX_LOST = 3'b010,
		PMEV_KIND_CPU_LOST = 3'b011,
		PMEV_KIND_POS = 3'b100,
		PMEV_KIND_WORKING = 3'b101,
		PMEV_KIND_RSVD6 = 3'b110,
		PMEV_KIND_RSVD7 = 3'b111
	} pmev_kind_e;
	typedef enum logic [1:0] {
		PMEV_BTN_IDLE = 2'b00,
		PMEV_BTN_DEBOUNCE = 2'b01,
		PMEV_BTN_HELD = 2'b10,
		PMEV_BTN_OVERRIDDEN = 2'b11
	} pmev_btn_e;
endpackage

// ===== testbench/test_pmev_bank.sv
// self-checking bench for the pm event register bank
`timescale 1ns/1ps
`include "pmev_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("FAIL %0t: got %h want %h", $time, (a), (b)); end end
module test_pmev_bank import pmev_pkg::*;;
	// ----------------------------------------
	// signals and design
	// ----------------------------------------
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] io_addr_in = 8'h00;
	logic io_wr_in = 1'b0;
	logic io_rd_in = 1'b0;
	logic [15:0] io_wdata_in = 16'h0000;
	logic button_in_n = 1'b1;
	logic [3:0] pci_request_inputs_in = 4'h0;
	logic pcpci_hold_request_n_in = 1'b1;
	logic timer_msb_in = 1'b0;
	logic alarm_in = 1'b0;
	wire logic [15:0] io_rdata_out;
	wire logic control_method_interrupt_out;
	wire logic system_mgmt_interrupt_n_out;
	wire logic resume_event_out;
	wire logic suspend_start_out;
	wire logic [2:0] suspend_kind_out;
	wire logic suspend_kind_valid_out;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	int resumes = 0;
	int starts = 0;
	logic [2:0] last_kind = 3'h0;
	logic [31:0] seed = 32'hD4C49DFD;

	// short counts keep the button tests to a few dozen cycles
	pmev_bank #(.DEBOUNCE_CYC(8), .OVERRIDE_CYC(40)) i_pmev_bank (
		.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .io_addr_in(io_addr_in),
		.io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
		.io_rdata_out(io_rdata_out), .button_in_n(button_in_n),
		.pci_request_inputs_in(pci_request_inputs_in),
		.pcpci_hold_request_n_in(pcpci_hold_request_n_in), .timer_msb_in(timer_msb_in),
		.alarm_in(alarm_in), .control_method_interrupt_out(control_method_interrupt_out),
		.system_mgmt_interrupt_n_out(system_mgmt_interrupt_n_out),
		.resume_event_out(resume_event_out), .suspend_start_out(suspend_start_out),
		.suspend_kind_out(suspend_kind_out), .suspend_kind_valid_out(suspend_kind_valid_out)
	);

	// ----------------------------------------
	// clock, pulse counters and hang guard
	// ----------------------------------------
	always #4 clk_sys_in = ~clk_sys_in;

	// pulses last one cycle, so they are counted rather than polled
	always @(posedge clk_sys_in) begin
		cycles++;
		if (resume_event_out === 1'b1) resumes++;
		if (suspend_start_out === 1'b1) begin
			starts++;
			last_kind <= suspend_kind_out;
		end
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	// strobe held one edge; effect lands by the #1 after that edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		io_wr_in <= 1'b1;
		io_addr_in <= a;
		io_wdata_in <= d;
		@(posedge clk_sys_in);
		io_wr_in <= 1'b0;
		#1;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] want);
		@(posedge clk_sys_in);
		io_rd_in <= 1'b1;
		io_addr_in <= a;
		@(posedge clk_sys_in);
		io_rd_in <= 1'b0;
		#1;
		`CHK(io_rdata_out, want)
	endtask

	// button held low for n cycles, then settle past the synchroniser
	task automatic press(input int n);
		@(posedge clk_sys_in);
		button_in_n <= 1'b0;
		cyc(n);
		button_in_n <= 1'b1;
		cyc(6);
	endtask

	task automatic bm(input logic [3:0] req, input logic hold_n);
		@(posedge clk_sys_in);
		pci_request_inputs_in <= req;
		pcpci_hold_request_n_in <= hold_n;
		cyc(3);
		pci_request_inputs_in <= 4'h0;
		pcpci_hold_request_n_in <= 1'b1;
		cyc(5);
	endtask

	task automatic end_sim();
		if (miscompares == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] v;
		logic [2:0] kk;
		int n;
		cyc(3);
		rst_b_in <= 1'b1;
		chk_rd(8'h00, 16'h0000);
		chk_rd(8'h02, `PMEV_ENABLE_RESET);
		chk_rd(8'h04, `PMEV_CONTROL_RESET);
		`CHK(system_mgmt_interrupt_n_out, 1'b1)
		chk_rd(8'h06, 16'h0000);
		// random enable and kind values; trigger and release kept clear
		for (int i = 0; i < 4; i++) begin
			v = 16'(xs());
			wr(8'h02, v);
			chk_rd(8'h02, v & `PMEV_ENABLE_MASK);
			v = 16'(xs()) & 16'hDFFB;
			wr(8'h04, v);
			chk_rd(8'h04, v & `PMEV_CONTROL_MASK);
		end
		wr(8'h02, 16'h0000);
		// every suspend kind, back to back
		for (int k = 0; k < 8; k++) begin
			kk = k[2:0];
			wr(8'h04, 16'h2000 | {3'b000, kk, 10'h000});
			`CHK(suspend_start_out, 1'b1)
			`CHK(suspend_kind_out, kk)
			`CHK(suspend_kind_valid_out, kk < 3'b110)
			chk_rd(8'h04, {3'b000, kk, 10'h000});
		end
		// timer msb toggles both ways
		@(posedge clk_sys_in) timer_msb_in <= 1'b1;
		cyc(5);
		chk_rd(8'h00, 16'h0001);
		`CHK(control_method_interrupt_out, 1'b0)
		wr(8'h00, 16'h0000);
		chk_rd(8'h00, 16'h0001);
		wr(8'h00, 16'h0001);
		chk_rd(8'h00, 16'h0000);
		wr(8'h02, 16'h0001);
		@(posedge clk_sys_in) timer_msb_in <= 1'b0;
		cyc(5);
		#1;
		`CHK(control_method_interrupt_out, 1'b1)
		wr(8'h00, 16'h0001);
		cyc(2);
		#1;
		`CHK(control_method_interrupt_out, 1'b0)
		// one random pci request alone, then hold alone
		v = 16'(xs());
		bm(4'h1 << v[1:0], 1'b1);
		chk_rd(8'h00, 16'h0010);
		wr(8'h00, 16'h0000);
		chk_rd(8'h00, 16'h0010);
		wr(8'h00, 16'h0010);
		bm(4'h0, 1'b0);
		chk_rd(8'h00, 16'h0010);
		wr(8'h00, 16'h0010);
		// firmware release, gated then enabled
		wr(8'h04, 16'h0004);
		chk_rd(8'h00, 16'h0020);
		`CHK(control_method_interrupt_out, 1'b0)
		wr(8'h02, 16'h0020);
		cyc(2);
		#1;
		`CHK(control_method_interrupt_out, 1'b1)
		wr(8'h00, 16'h0020);
		cyc(2);
		#1;
		`CHK(control_method_interrupt_out, 1'b0)
		// alarm without and with its resume enable
		n = resumes;
		for (int e = 0; e < 2; e++) begin
			wr(8'h02, e ? 16'h0400 : 16'h0000);
			@(posedge clk_sys_in) alarm_in <= 1'b1;
			cyc(4);
			alarm_in <= 1'b0;
			cyc(4);
			chk_rd(8'h00, 16'h0400);
			`CHK(resumes, n + e)
			wr(8'h00, 16'h0400);
		end
		// button: bounce, press without and with enable
		wr(8'h02, 16'h0000);
		press(4);
		chk_rd(8'h00, 16'h0000);
		n = resumes;
		press(20);
		chk_rd(8'h00, 16'h0100);
		`CHK(resumes, n + 1)
		`CHK(system_mgmt_interrupt_n_out, 1'b1)
		wr(8'h00, 16'h0100);
		wr(8'h02, 16'h0100);
		press(20);
		`CHK(system_mgmt_interrupt_n_out, 1'b0)
		`CHK(control_method_interrupt_out, 1'b1)
		wr(8'h00, 16'h0100);
		cyc(2);
		#1;
		`CHK(system_mgmt_interrupt_n_out, 1'b1)
		// long press overrides with kind 7 still programmed
		wr(8'h04, 16'h1C00);
		n = starts;
		press(60);
		chk_rd(8'h00, 16'h0800);
		`CHK(starts, n + 1)
		`CHK(last_kind, 3'b000)
		end_sim();
	end
endmodule // test_pmev_bank
